// file: rtl/cophp_port.sv
`timescale 1ns/1ps
// Contract
// - shared 32-bit bus, valid at clock fall
// - processor gates coprocessor clock with qualifier
// - absent high at sample traps as undefined
// - absent low: wait for busy low, complete
// - busy sampled each cycle instruction indicator low
// - fetch indicator low on fetch, high data
// - instruction indicator low during coprocessor instruction
// - user indicator low in user mode
// - compact state high for 16-bit set
module cophp_port (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // core side
  input  wire logic        i_core_fetch,
  input  wire logic        i_core_user,
  input  wire logic        i_core_compact,
  input  wire logic        i_cop_req,
  input  wire logic        i_cop_to_cop,
  input  wire logic [31:0] i_cop_wdata,
  input  wire logic [31:0] i_internal_data_bus,
  input  wire logic        i_stall,
  output logic             o_cop_done,
  output logic             o_cop_trap,
  output logic [31:0]      o_cop_rdata,
  output logic             o_cop_rvalid,
  // coprocessor pins
  output logic             o_cop_clock,
  output logic             o_cop_clock_qualifier_n,
  input  wire logic [31:0] i_cop_data_bus,
  output logic [31:0]      o_cop_data_bus,
  output logic             o_cop_data_bus_oe,
  input  wire logic        i_cop_data_drive_en,
  input  wire logic        i_cop_test_read,
  input  wire logic        i_cop_test_write,
  input  wire logic        i_cop_absent,
  input  wire logic        i_cop_busy,
  output logic             o_fetch_indicator_n,
  output logic             o_cop_instr_indicator_n,
  output logic             o_user_mode_indicator_n,
  output logic             o_compact_isa_state
);
  import cophp_pkg::*;

  cophp_state_e state;        // handshake state
  logic [1:0]   pins_s;       // synced absent and busy
  logic [31:0]  bus_s;        // synced coprocessor data bus
  logic         dbe_s;        // synced drive enable
  logic         trd_s;        // synced test read
  logic         twr_s;        // synced test write
  logic         absent_s;     // synced absent
  logic         busy_s;       // synced busy
  logic         cop_phase;    // low/high phase of exported clock
  logic         fall_now;     // next edge makes the exported clock fall
  logic         test_drive;   // legal test access, reset only

  // handshake pins pass two flops before use
  cophp_sync #(.W(2)) u_sync_ctl (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_cop_absent, i_cop_busy}),
    .o_q   (pins_s)
  );
  cophp_sync #(.W(DATA_W)) u_sync_bus (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_cop_data_bus),
    .o_q   (bus_s)
  );
  // test strobes and drive enable are read while reset holds,
  // so their stage pair must not be cleared by reset
  logic [2:0] tst_meta;  // first stage: drive enable, test read, write
  always_ff @(posedge i_clk) begin
    tst_meta              <= {i_cop_data_drive_en, i_cop_test_read,
                              i_cop_test_write};
    {dbe_s, trd_s, twr_s} <= tst_meta;
  end

  assign absent_s = pins_s[1];
  assign busy_s   = pins_s[0];
  assign fall_now = cop_phase;
  // both strobes high is illegal, so neither wins
  assign test_drive = i_rst && (trd_s ^ twr_s);

  // exported coprocessor clock, divided from the system clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cop_phase   <= 1'b0;
      o_cop_clock <= 1'b0;
    end else begin
      cop_phase   <= ~cop_phase;
      o_cop_clock <= ~cop_phase;
    end
  end

  // clock qualifier: low stalls transfers for this cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cop_clock_qualifier_n <= 1'b1;
    end else begin
      o_cop_clock_qualifier_n <= ~i_stall;
    end
  end

  // pipeline tracking outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fetch_indicator_n     <= RST_FETCH_N;
      o_user_mode_indicator_n <= RST_USER_N;
      o_compact_isa_state     <= RST_COMPACT;
    end else begin
      o_fetch_indicator_n     <= ~i_core_fetch;
      o_user_mode_indicator_n <= ~i_core_user;
      o_compact_isa_state     <= i_core_compact;
    end
  end

  // handshake state machine; sampling only on exported clock fall
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= COPHP_IDLE;
    end else begin
      case (state)
        COPHP_IDLE: begin
          // wait for a falling edge to start the cycle cleanly
          if (i_cop_req && fall_now) begin
            state <= COPHP_ISSUE;
          end
        end
        COPHP_ISSUE: begin
          // end of high phase of the issue cycle decides trap
          if (fall_now) begin
            if (absent_s) begin
              state <= COPHP_TRAP;
            end else if (busy_s) begin
              state <= COPHP_WAIT;
            end else begin
              state <= COPHP_XFER;
            end
          end
        end
        COPHP_WAIT: begin
          // busy resampled at every unstalled clock fall
          if (fall_now && !i_stall) begin
            if (absent_s) begin
              state <= COPHP_TRAP;
            end else if (!busy_s) begin
              state <= COPHP_XFER;
            end
          end
        end
        COPHP_XFER: begin
          // data valid at the falling edge
          if (fall_now && !i_stall) begin
            state <= COPHP_DONE;
          end
        end
        COPHP_DONE: state <= COPHP_IDLE;
        COPHP_TRAP: state <= COPHP_IDLE;
        default:    state <= COPHP_IDLE;
      endcase
    end
  end

  // instruction indicator low throughout the handshake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cop_instr_indicator_n <= RST_CPI_N;
    end else begin
      o_cop_instr_indicator_n <=
        !(state == COPHP_ISSUE || state == COPHP_WAIT ||
          state == COPHP_XFER);
    end
  end

  // completion and trap pulses to the core
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cop_done <= 1'b0;
      o_cop_trap <= 1'b0;
    end else begin
      o_cop_done <= (state == COPHP_DONE);
      o_cop_trap <= (state == COPHP_TRAP);
    end
  end

  // read capture from coprocessor at the falling edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cop_rdata  <= RST_DATA;
      o_cop_rvalid <= 1'b0;
    end else begin
      o_cop_rvalid <= 1'b0;
      if (state == COPHP_XFER && fall_now && !i_stall &&
          !i_cop_to_cop && dbe_s) begin
        o_cop_rdata  <= bus_s;
        o_cop_rvalid <= 1'b1;
      end
    end
  end

  // bus drive: never while coprocessor claims it
  // test access drives internal data during reset
  always_ff @(posedge i_clk) begin
    if (test_drive) begin
      o_cop_data_bus    <= i_internal_data_bus;
      o_cop_data_bus_oe <= !dbe_s;
    end else if (i_rst) begin
      o_cop_data_bus    <= RST_DATA;
      o_cop_data_bus_oe <= 1'b0;
    end else begin
      o_cop_data_bus    <= i_cop_wdata;
      o_cop_data_bus_oe <= (state == COPHP_XFER) && i_cop_to_cop &&
                           !dbe_s;
    end
  end
endmodule

// file: rtl/cophp_pkg.sv
package cophp_pkg;
  // data bus width
  localparam int          DATA_W        = 32;
  // system clock rate, and half-period of the exported coprocessor clock in system clocks
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          COP_HALF      = 1;
  // reset values of the tracking outputs (all inactive except user indicator, reset low)
  localparam logic        RST_FETCH_N   = 1'b1;
  localparam logic        RST_CPI_N     = 1'b1;
  localparam logic        RST_USER_N    = 1'b0;
  localparam logic        RST_COMPACT   = 1'b0;
  localparam logic [31:0] RST_DATA      = 32'h0000_0000;

  // coprocessor handshake states
  typedef enum logic [2:0] {
    COPHP_IDLE,
    COPHP_ISSUE,
    COPHP_WAIT,
    COPHP_XFER,
    COPHP_DONE,
    COPHP_TRAP
  } cophp_state_e;
endpackage

// file: rtl/cophp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs; first stage is read only by second
module cophp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;  // first stage, metastability catch

  // two stages, cleared by reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

// file: verif/cophp_chk_sva.sv
`timescale 1ns/1ps
// pin checks of the coprocessor port, one clock domain
module cophp_chk (
  input logic i_clk,
  input logic i_rst,
  input logic i_stall,
  input logic i_core_fetch,
  input logic i_core_user,
  input logic i_core_compact,
  input logic i_cop_absent,
  input logic i_cop_busy,
  input logic i_cop_data_drive_en,
  input logic o_cop_done,
  input logic o_cop_trap,
  input logic o_cop_data_bus_oe,
  input logic o_cop_instr_indicator_n,
  input logic o_cop_clock_qualifier_n,
  input logic o_fetch_indicator_n,
  input logic o_user_mode_indicator_n,
  input logic o_compact_isa_state
);
  logic up; // previous edge was out of reset
  always_ff @(posedge i_clk) up <= !i_rst;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // eight edges of absent or busy leave no room to finish
  sequence s_hold; (i_cop_absent || i_cop_busy) [*8]; endsequence
  property p_hold; s_hold |-> !o_cop_done; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_trap; !i_cop_absent [*8] |-> !o_cop_trap; endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_oe; i_cop_data_drive_en [*4] |-> !o_cop_data_bus_oe; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_cpi;
    o_cop_done |-> !$past(o_cop_instr_indicator_n, 2); endproperty
  a_cpi: assert property (p_cpi) else $error("cpi");
  property p_qual;
    up |-> o_cop_clock_qualifier_n == !$past(i_stall); endproperty
  a_qual: assert property (p_qual) else $error("qual");
  property p_fch; up |-> o_fetch_indicator_n == !$past(i_core_fetch);
  endproperty
  a_fch: assert property (p_fch) else $error("fetch");
  property p_usr; up |-> o_user_mode_indicator_n == !$past(i_core_user);
  endproperty
  a_usr: assert property (p_usr) else $error("user");
  property p_isa; up |-> o_compact_isa_state == $past(i_core_compact);
  endproperty
  a_isa: assert property (p_isa) else $error("isa");
endmodule
bind cophp_port cophp_chk u_chk (.*);

// file: verif/cophp_cop.sv
`timescale 1ns/1ps
// behavioural coprocessor facing the port
module cophp_cop (
  input  logic        i_clk,
  input  logic        i_cop_clock,
  input  logic        i_cpi_n,
  input  logic        i_oe,
  input  logic [31:0] i_dout,
  input  logic [31:0] i_rd,
  input  logic        i_present,
  input  logic        i_drive,
  input  logic [3:0]  i_wait,
  output logic        o_absent,
  output logic        o_busy,
  output logic        o_drive_en,
  output logic [31:0] o_bus,
  output logic [31:0] o_got
);
  logic [3:0] cnt; // cycles left before it can start
  // reload while idle, so busy stands before the indicator falls
  always @(posedge i_clk) cnt <= i_cpi_n ? i_wait : cnt - 4'(cnt != 4'h0);
  assign o_busy = cnt != 4'h0;
  assign o_absent = !i_present;
  // no coprocessor: enable stays low
  assign o_drive_en = i_present && i_drive;
  // own word when enabled; released bus shows the inverse, never stale
  assign o_bus = i_oe ? i_dout : o_drive_en ? i_rd : ~i_dout;
  // word taken where the exported clock falls
  always @(negedge i_cop_clock) if (i_oe) o_got <= i_dout;
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'h0, i_rst = 1'h1, i_stall = 1'h0, i_cop_req = 1'h0;
  logic i_core_fetch = 1'h0, i_core_user = 1'h0, i_core_compact = 1'h0;
  logic i_cop_to_cop = 1'h0, i_cop_test_read = 1'h0;
  logic i_cop_test_write = 1'h0, prs = 1'h0, drv = 1'h0;
  logic [31:0] i_cop_wdata = 32'h0, i_internal_data_bus = 32'h0;
  logic [31:0] i_cop_data_bus, o_cop_data_bus, o_cop_rdata, got;
  logic i_cop_data_drive_en, i_cop_absent, i_cop_busy, o_cop_done;
  logic o_cop_trap, o_cop_rvalid, o_cop_clock, o_cop_clock_qualifier_n;
  logic o_cop_data_bus_oe, o_fetch_indicator_n, o_cop_instr_indicator_n;
  logic o_user_mode_indicator_n, o_compact_isa_state;
  logic [3:0] wt = 4'h0; // partner busy cycles
  logic [31:0] rv = 32'h0; // word the partner returns on a read
  int mismatches = 0, tests_run = 0;
  always #50 i_clk = ~i_clk; // 10 MHz
  cophp_port uut (.*);
  cophp_cop cop (.i_clk(i_clk), .i_cop_clock(o_cop_clock),
    .i_cpi_n(o_cop_instr_indicator_n), .i_oe(o_cop_data_bus_oe),
    .i_dout(o_cop_data_bus), .i_rd(rv), .i_present(prs), .i_drive(drv),
    .i_wait(wt), .o_absent(i_cop_absent), .o_busy(i_cop_busy),
    .o_drive_en(i_cop_data_drive_en), .o_bus(i_cop_data_bus), .o_got(got));
  task tick(input int n); repeat (n) @(posedge i_clk); #10; endtask
  task check(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // every mix of core state; per-cycle checks live in the checker
  task t_track;
    logic c;
    for (int i = 0; i < 16; i++) begin
      {i_stall, i_core_fetch, i_core_user, i_core_compact} = 4'(i);
      tick(1);
    end
    check("qual", o_cop_clock_qualifier_n, 1'h0);
    check("isa", o_compact_isa_state, 1'h1);
    check("fch", o_fetch_indicator_n, 1'h0);
    check("usr", o_user_mode_indicator_n, 1'h0);
    {i_stall, i_core_fetch, i_core_user, i_core_compact} = 4'h0;
    c = o_cop_clock;
    tick(1);
    check("clk", o_cop_clock, !c);
    check("qual1", o_cop_clock_qualifier_n, 1'h1);
    check("fch1", o_fetch_indicator_n, 1'h1);
    check("usr1", o_user_mode_indicator_n, 1'h1);
    check("isa0", o_compact_isa_state, 1'h0);
  endtask
  // one instruction: p present, d to coprocessor, s stalls the
  // first eight cycles, w busy cycles
  task t_op(input logic p, d, s, input logic [3:0] w,
            input logic [31:0] v);
    logic lo, rs, bad;
    int k;
    lo = 1'h0;
    rs = 1'h0;
    bad = 1'h0;
    prs = p;
    drv = !d;
    wt = w;
    rv = v;
    i_cop_to_cop = d;
    i_cop_wdata = d ? v : ~v;
    tick(4);
    i_cop_req = 1'h1;
    for (k = 0; k < 300 && !o_cop_done && !o_cop_trap; k++) begin
      i_stall = s && k < 8;
      tick(1);
      if (o_cop_instr_indicator_n === 1'h0) lo = 1'h1;
      if (o_cop_data_bus_oe !== 1'h0 && !d) bad = 1'h1;
      if (o_cop_rvalid === 1'h1) begin
        rs = 1'h1;
        check("rd", o_cop_rdata, v);
      end
    end
    i_stall = 1'h0;
    check("trap", o_cop_trap, !p);
    check("done", o_cop_done, p);
    check("rv", rs, p && !d);
    check("oe", bad, 1'h0);
    if (p && w == 4'h0) check("lat", k > 8, s);
    i_cop_req = 1'h0;
    check("cpi", lo, 1'h1);
    if (p && d) check("wr", got, v);
    tick(2);
  endtask
  // test access while held in reset; both strobes drive nothing
  task t_test;
    i_rst = 1'h1;
    drv = 1'h0;
    i_internal_data_bus = 32'h3c5a_96e1;
    i_cop_test_write = 1'h1;
    tick(6);
    check("tw", o_cop_data_bus, i_internal_data_bus);
    check("twoe", o_cop_data_bus_oe, 1'h1);
    i_cop_test_read = 1'h1;
    tick(6);
    check("both", o_cop_data_bus_oe, 1'h0);
    i_cop_test_write = 1'h0;
    i_internal_data_bus = 32'h69a5_c30f;
    tick(6);
    check("tr", o_cop_data_bus, i_internal_data_bus);
    check("troe", o_cop_data_bus_oe, 1'h1);
    i_cop_test_read = 1'h0;
    tick(4);
    i_rst = 1'h0;
    tick(2);
    check("rel", o_cop_data_bus_oe, 1'h0);
  endtask
  initial begin
    tick(16);
    i_rst = 1'h0;
    t_track;
    t_op(1'h0, 1'h0, 1'h0, 4'h0, 32'h0);
    t_op(1'h1, 1'h1, 1'h1, 4'h0, 32'ha5c3_0f71);
    t_op(1'h1, 1'h0, 1'h0, 4'h5, 32'h1e2d_3c4b);
    t_op(1'h1, 1'h1, 1'h0, 4'hc, 32'hf00d_5a69);
    t_test;
    t_op(1'h1, 1'h0, 1'h0, 4'h0, 32'h8421_7bde);
    report_and_stop;
  end
  // hang guard, well past the expected run
  initial begin
    #1000000;
    mismatches++;
    report_and_stop;
  end
endmodule
